/* File: verilog/cwd_pkg.sv */
`default_nettype none
package cwd_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CFG_WORD  = 8'h00; // raw word, as read back
	localparam logic [7:0] ADDR_CFG_STAT  = 8'h04; // decoded settings
	localparam logic [7:0] ADDR_CFG_CTRL  = 8'h08; // reload strobe, timer tick

	// ------------------------------------------------------------
	// configuration word layout
	// ------------------------------------------------------------
	localparam int unsigned POS_MODE_HI    = 15;
	localparam int unsigned POS_MODE_MID   = 6;
	localparam int unsigned POS_MODE_LO    = 4;
	localparam int unsigned POS_WDOG_LO    = 2;
	localparam int unsigned POS_OSC_LO     = 0;
	localparam logic [15:0] UNIMPL_ONE_MSK  = 16'h7e00; // bits 14..9
	localparam logic [15:0] UNIMPL_ZERO_MSK = 16'h00a0; // bits 7 and 5
	localparam logic [15:0] PROG_MSK        = 16'h805f; // programmable bits
	localparam logic [15:0] ERASED_WORD     = 16'hffff; // erased value

	// ------------------------------------------------------------
	// field encodings
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_CODE_MPU   = 3'h7;
	localparam logic [2:0] MODE_CODE_MCU   = 3'h6;
	localparam logic [2:0] MODE_CODE_EXT   = 3'h5;
	localparam logic [2:0] MODE_CODE_PROT  = 3'h0;
	localparam logic [1:0] WDOG_CODE_PS1   = 2'h3;
	localparam logic [1:0] WDOG_CODE_PS256 = 2'h2;
	localparam logic [1:0] WDOG_CODE_PS64  = 2'h1;
	localparam logic [1:0] WDOG_CODE_OFF   = 2'h0;
	localparam logic [1:0] OSC_CODE_EC     = 2'h3;
	localparam logic [1:0] OSC_CODE_XT     = 2'h2;
	localparam logic [1:0] OSC_CODE_RC     = 2'h1;
	localparam logic [1:0] OSC_CODE_LF     = 2'h0;
	localparam logic [8:0] PSCALE_1        = 9'h001;
	localparam logic [8:0] PSCALE_64       = 9'h040;
	localparam logic [8:0] PSCALE_256      = 9'h100;
	localparam int unsigned WDOG_CNT_W     = 16;

	typedef enum logic [2:0] {
		CWD_MODE_MPU,
		CWD_MODE_MCU,
		CWD_MODE_EXT,
		CWD_MODE_PROT,
		CWD_MODE_RSVD
	} cwd_mode_t;

	typedef enum logic [1:0] {
		CWD_OSC_EC,
		CWD_OSC_XT,
		CWD_OSC_RC,
		CWD_OSC_LF
	} cwd_osc_t;

	// decoded settings travel together
	typedef struct packed {
		cwd_mode_t  mode;
		cwd_osc_t   osc;
		logic       wdog_en;
		logic [8:0] wdog_pscale;
	} cwd_cfg_t;
endpackage
`default_nettype wire

/* File: verilog/cwd_decode.sv */
`timescale 1ns/1ps
`default_nettype none
// pure decode of the stored word into settings
module cwd_decode (
	input  wire logic [15:0]      word_in,
	output cwd_pkg::cwd_cfg_t     cfg_out
);
	logic [2:0] mode_code;
	logic [1:0] wdog_code;
	logic [1:0] osc_code;

	// ------------------------------------------------------------
	// field extraction
	// ------------------------------------------------------------
	assign mode_code = {word_in[cwd_pkg::POS_MODE_HI],
		word_in[cwd_pkg::POS_MODE_MID],
		word_in[cwd_pkg::POS_MODE_LO]};
	assign wdog_code = word_in[cwd_pkg::POS_WDOG_LO +: 2];
	assign osc_code  = word_in[cwd_pkg::POS_OSC_LO +: 2];

	// ------------------------------------------------------------
	// code tables
	// ------------------------------------------------------------
	// undefined mode codes are flagged reserved, not guessed at
	always_comb begin
		case (mode_code)
			cwd_pkg::MODE_CODE_MPU:  cfg_out.mode = cwd_pkg::CWD_MODE_MPU;
			cwd_pkg::MODE_CODE_MCU:  cfg_out.mode = cwd_pkg::CWD_MODE_MCU;
			cwd_pkg::MODE_CODE_EXT:  cfg_out.mode = cwd_pkg::CWD_MODE_EXT;
			cwd_pkg::MODE_CODE_PROT: cfg_out.mode = cwd_pkg::CWD_MODE_PROT;
			default:                 cfg_out.mode = cwd_pkg::CWD_MODE_RSVD;
		endcase
		case (osc_code)
			cwd_pkg::OSC_CODE_EC: cfg_out.osc = cwd_pkg::CWD_OSC_EC;
			cwd_pkg::OSC_CODE_XT: cfg_out.osc = cwd_pkg::CWD_OSC_XT;
			cwd_pkg::OSC_CODE_RC: cfg_out.osc = cwd_pkg::CWD_OSC_RC;
			default:              cfg_out.osc = cwd_pkg::CWD_OSC_LF;
		endcase
		cfg_out.wdog_en = (wdog_code != cwd_pkg::WDOG_CODE_OFF);
		case (wdog_code)
			cwd_pkg::WDOG_CODE_PS1:   cfg_out.wdog_pscale = cwd_pkg::PSCALE_1;
			cwd_pkg::WDOG_CODE_PS256: cfg_out.wdog_pscale = cwd_pkg::PSCALE_256;
			cwd_pkg::WDOG_CODE_PS64:  cfg_out.wdog_pscale = cwd_pkg::PSCALE_64;
			default:                  cfg_out.wdog_pscale = cwd_pkg::PSCALE_1;
		endcase
	end
endmodule
`default_nettype wire

/* File: verilog/cwd_top.sv */
// Overview of operation
// - unimplemented bits 14..9 read back as one; bit 15 is a mode bit.
// - the mode code is bits 15, 6, 4 with bit 15 the most significant.
// - mode 111 processor, 110 controller, 101 extended, 000 protected.
// - unimplemented bits 7 and 5 read back as zero.
// - bits 3-2 select the watchdog: 11 scale 1, 10 scale 256, 01 scale 64.
// - code 00 stops watchdog resets; the counter is a 16-bit overflow timer.
// - bits 1-0 pick the clock: 11 external, 10 crystal, 00 low-freq crystal.
// - an erased device reads every programmable bit as one.
// - no run-time path can switch the watchdog off; only the stored word can. Here a CTRL write clearing bit 1 stops the tick and so the watchdog.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cwd_top (
	input  wire logic        clk_sys_in,
	input  wire logic        resetn_in,
	input  wire logic        clk_en_in,
	input  wire logic [15:0] nv_word_in,
	input  wire logic        nv_erased_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic             pready_out,
	output logic             pslverr_out,
	output logic [31:0]      prdata_out,
	output cwd_pkg::cwd_cfg_t cfg_out,
	output logic             wdog_reset_out,
	output logic             tmr_ovf_out
);
	logic [15:0]              word_reg;
	logic [15:0]              word_next;
	cwd_pkg::cwd_cfg_t        dec_cfg;
	logic [cwd_pkg::WDOG_CNT_W-1:0] cnt_reg;
	logic [8:0]               ps_reg;
	logic                     tick_reg;
	logic                     load_reg;
	logic                     cnt_wrap;
	logic                     ps_done;
	logic                     apb_acc;
	logic [31:0]              rd_next;

	// ------------------------------------------------------------
	// stored word capture
	// ------------------------------------------------------------
	// erased parts read all ones in programmable places
	always_comb begin
		word_next = nv_erased_in ? cwd_pkg::ERASED_WORD : nv_word_in;
		word_next = (word_next & cwd_pkg::PROG_MSK)
			| cwd_pkg::UNIMPL_ONE_MSK;
		word_next = word_next & ~cwd_pkg::UNIMPL_ZERO_MSK;
	end

	// captured after reset release and on a reload request only, so
	// settings never shift under the core mid-run
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			load_reg <= 1'b1;
			word_reg <= cwd_pkg::ERASED_WORD & ~cwd_pkg::UNIMPL_ZERO_MSK;
		end else if (clk_en_in) begin
			load_reg <= 1'b0;
			if (load_reg)
				word_reg <= word_next;
			else if (apb_acc && pwrite_in && paddr_in == cwd_pkg::ADDR_CFG_CTRL
				&& pwdata_in[0])
				word_reg <= word_next;
		end
	end

	cwd_decode u_dec (
		.word_in (word_reg),
		.cfg_out (dec_cfg)
	);

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in)
			cfg_out <= '0;
		else if (clk_en_in)
			cfg_out <= dec_cfg;
	end

	// ------------------------------------------------------------
	// watchdog counter
	// ------------------------------------------------------------
	assign cnt_wrap = (cnt_reg == '1);
	assign ps_done  = (ps_reg + 9'h001 >= dec_cfg.wdog_pscale);

	// counter and postscaler run on the timer tick from software
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			cnt_reg        <= '0;
			ps_reg         <= '0;
			wdog_reset_out <= 1'b0;
			tmr_ovf_out    <= 1'b0;
		end else if (clk_en_in) begin
			wdog_reset_out <= 1'b0;
			tmr_ovf_out    <= 1'b0;
			if (tick_reg) begin
				cnt_reg <= cnt_reg + 1'b1;
				if (cnt_wrap) begin
					tmr_ovf_out <= 1'b1;
					if (ps_done) begin
						ps_reg <= '0;
						// the stored word and the CTRL tick both gate this
						wdog_reset_out <= dec_cfg.wdog_en;
					end else
						ps_reg <= ps_reg + 9'h001;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	assign apb_acc = psel_in && penable_in && pready_out;

	// read mux; raw word and decoded view
	always_comb begin
		case (paddr_in)
			cwd_pkg::ADDR_CFG_WORD: rd_next = {16'h0000, word_reg};
			cwd_pkg::ADDR_CFG_STAT: rd_next = {16'h0000,
				dec_cfg.wdog_pscale, dec_cfg.wdog_en,
				dec_cfg.osc, 1'b0, dec_cfg.mode};
			cwd_pkg::ADDR_CFG_CTRL: rd_next = {31'h00000000, tick_reg};
			default:                rd_next = 32'h00000000;
		endcase
	end

	// no wait state: answer in the cycle after setup
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= '0;
			tick_reg    <= 1'b0;
		end else if (clk_en_in) begin
			pready_out  <= psel_in && !penable_in;
			pslverr_out <= 1'b0;
			if (psel_in && !penable_in) begin
				prdata_out  <= pwrite_in ? 32'h00000000 : rd_next;
				pslverr_out <= (paddr_in != cwd_pkg::ADDR_CFG_WORD)
					&& (paddr_in != cwd_pkg::ADDR_CFG_STAT)
					&& (paddr_in != cwd_pkg::ADDR_CFG_CTRL);
			end
			// word and status are read only; a CTRL write with bit 1 clear halts the dog's tick
			if (apb_acc && pwrite_in && paddr_in == cwd_pkg::ADDR_CFG_CTRL)
				tick_reg <= pwdata_in[1];
		end
	end
endmodule
`default_nettype wire

/* File: sim/cwd_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module cwd_top_props (
	input wire logic              clk_sys_in,
	input wire logic              resetn_in,
	input wire logic              pwrite_in,
	input wire logic [7:0]        paddr_in,
	input wire logic              pready_out,
	input wire logic              pslverr_out,
	input wire logic [31:0]       prdata_out,
	input wire cwd_pkg::cwd_cfg_t cfg_out,
	input wire logic              wdog_reset_out,
	input wire logic              tmr_ovf_out
);
	// ------------------------------------------------------------
	// readback of the raw word against the decoded settings; watchdog and overflow pulses
	// ------------------------------------------------------------
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	logic       rdw;
	logic [2:0] mc;
	// a word read is the one moment both views are visible at once
	assign rdw = pready_out && !pwrite_in
		&& paddr_in == cwd_pkg::ADDR_CFG_WORD;
	assign mc  = {prdata_out[15], prdata_out[6], prdata_out[4]};
	a_upper_ones: assert property (rdw |-> prdata_out[14:9] == 6'h3f)
		else $error("upper bits not one");
	a_gap_zeros: assert property (rdw |->
		!prdata_out[7] && !prdata_out[5])
		else $error("gap bits not zero");
	a_mode_ext: assert property (rdw && mc == 3'h5 |->
		cfg_out.mode == cwd_pkg::CWD_MODE_EXT)
		else $error("mode 101 misdecoded");
	a_osc_map: assert property (rdw |->
		cfg_out.osc == ~prdata_out[1:0])
		else $error("osc misdecoded");
	a_wdog_en: assert property (rdw |->
		cfg_out.wdog_en == |prdata_out[3:2])
		else $error("wdog enable wrong");
	a_scale_256: assert property (rdw && prdata_out[3:2] == 2'h2 |->
		cfg_out.wdog_pscale == 9'h100)
		else $error("postscale not 256");
	a_wdog_quiet: assert property (!cfg_out.wdog_en
		&& !$past(cfg_out.wdog_en) |-> !wdog_reset_out)
		else $error("reset while disabled");
	a_ovf_pulse: assert property (tmr_ovf_out |=> !tmr_ovf_out)
		else $error("overflow pulse too long");
	c_ovf: cover property (tmr_ovf_out);
	c_err: cover property (pready_out && pslverr_out);
	c_ext: cover property (rdw && mc == 3'h5);
	c_rsvd: cover property (cfg_out.mode == cwd_pkg::CWD_MODE_RSVD);
endmodule
`default_nettype wire

/* File: sim/cwd_prog_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cwd_prog_model (
	input  wire logic        clk_sys_in,
	input  wire logic        erase_in,
	input  wire logic        prog_in,
	input  wire logic [15:0] data_in,
	output logic [15:0]      nv_word_out,
	output logic             nv_erased_out
);
	// ------------------------------------------------------------
	// cell array: erase sets all, a program pass can only clear
	// ------------------------------------------------------------
	initial begin
		nv_word_out = 16'hffff;
		nv_erased_out = 1'b1;
	end
	always @(posedge clk_sys_in) begin
		if (erase_in) begin
			nv_word_out <= 16'hffff;
			nv_erased_out <= 1'b1;
		end else if (prog_in) begin
			nv_word_out <= nv_word_out & data_in;
			nv_erased_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: sim/config_word_decode_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module config_word_decode_tb;
	// ------------------------------------------------------------
	// stimulus, tasks and verdict
	// ------------------------------------------------------------
	logic              clk, rstn, sel, en, wr, rdy, perr, err, erase, prog;
	logic              nv_er, wrst, ovf, rst_seen;
	logic [7:0]        addr;
	logic [31:0]       wdata, rdata, rd;
	logic [15:0]       pdata, nv_word;
	cwd_pkg::cwd_cfg_t cfg;
	int                fails, comparisons;
	cwd_prog_model cwd_prog_model_i (.clk_sys_in(clk), .erase_in(erase),
		.prog_in(prog), .data_in(pdata), .nv_word_out(nv_word),
		.nv_erased_out(nv_er));
	cwd_top cwd_top_i (.clk_sys_in(clk), .resetn_in(rstn), .clk_en_in(1'b1),
		.nv_word_in(nv_word), .nv_erased_in(nv_er), .psel_in(sel),
		.penable_in(en), .pwrite_in(wr), .paddr_in(addr), .pwdata_in(wdata),
		.pready_out(rdy), .pslverr_out(perr), .prdata_out(rdata),
		.cfg_out(cfg), .wdog_reset_out(wrst), .tmr_ovf_out(ovf));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// any watchdog reset in this run is wrong: the tick only runs while the word has the watchdog off
	always @(posedge clk) if (wrst === 1'b1) rst_seen <= 1'b1;
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{sel, en, wr, addr, wdata} <= {2'b10, w, a, d};
		@(posedge clk);
		en <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		rd = rdata;
		err = perr;
		{sel, en} <= 2'b00;
	endtask
	// erase, optionally program, then reload the word into the block
	task burn(input logic p, input logic [15:0] w);
		@(posedge clk);
		erase <= 1'b1;
		@(posedge clk);
		{erase, prog, pdata} <= {1'b0, p, w};
		@(posedge clk);
		prog <= 1'b0;
		apb(1'b1, cwd_pkg::ADDR_CFG_CTRL, 32'h1);
	endtask
	task t_codes;
		logic [2:0] m[4] = '{3'h7, 3'h6, 3'h5, 3'h0};
		logic [8:0] ps[4] = '{9'h001, 9'h100, 9'h040, 9'h0};
		logic [1:0] c;
		burn(1'b0, 16'h0);
		apb(1'b0, cwd_pkg::ADDR_CFG_WORD, 32'h0);
		chk(rd & 32'hfeff, 32'hfe5f, "erased word");
		for (int i = 0; i < 4; i++) begin
			c = 2'h3 - 2'(i);
			burn(1'b1, {m[i][2], 7'h00, 1'b1, m[i][1], 1'b1, m[i][0], c, c});
			apb(1'b0, cwd_pkg::ADDR_CFG_WORD, 32'h0);
			chk(rd & 32'hfeff, {16'h0, m[i][2], 7'h7e, 1'b0, m[i][1], 1'b0,
				m[i][0], c, c}, "word");
			apb(1'b0, cwd_pkg::ADDR_CFG_STAT, 32'h0);
			// status: mode [2:0], osc [5:4], enable [6], scale [15:7]
			chk(rd & 32'h7f, {25'h0, |c, 2'(i), 1'b0, 3'(i)},
				"status");
			chk(32'(cfg[14:9]), {26'h0, 3'(i), 2'(i), |c}, "cfg");
			if (c != 2'h0) chk(32'(rd[15:7]), 32'(ps[i]), "scale");
		end
		$display("t_codes done");
	endtask
	task t_bus;
		burn(1'b1, 16'hfffd);
		apb(1'b0, 8'h0c, 32'h0);
		chk({rd[30:0], err}, 32'h1, "unmapped");
		apb(1'b1, cwd_pkg::ADDR_CFG_STAT, 32'h0);
		apb(1'b1, cwd_pkg::ADDR_CFG_WORD, 32'h0);
		apb(1'b1, cwd_pkg::ADDR_CFG_CTRL, 32'h0);
		apb(1'b0, cwd_pkg::ADDR_CFG_STAT, 32'h0);
		chk(32'(rd[6]), 32'h1, "wdog turned off");
		apb(1'b0, cwd_pkg::ADDR_CFG_WORD, 32'h0);
		chk(rd & 32'hfeff, 32'hfe5d, "word overwritten");
		// mode code 010 is not defined and must come out reserved
		burn(1'b1, 16'h7fef);
		apb(1'b0, cwd_pkg::ADDR_CFG_STAT, 32'h0);
		chk(rd & 32'h7, 32'h4, "reserved mode");
		$display("t_bus done");
	endtask
	task t_timer;
		int n;
		n = 0;
		burn(1'b1, 16'hfff0);
		apb(1'b1, cwd_pkg::ADDR_CFG_CTRL, 32'h2);
		while (ovf !== 1'b1 && n < 70000) begin
			@(posedge clk);
			n++;
		end
		// 65536 ticks to the wrap, one edge to register the pulse
		chk(32'(n), 32'h00010001, "wrap cycles");
		@(posedge clk);
		chk({31'h0, ovf}, 32'h0, "ovf pulse");
		chk({31'h0, rst_seen}, 32'h0, "dog reset seen");
		apb(1'b1, cwd_pkg::ADDR_CFG_CTRL, 32'h0);
		$display("t_timer done");
	endtask
	task end_sim;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		{rstn, sel, en, wr, erase, prog, rst_seen, addr} = '0;
		{wdata, pdata, fails, comparisons} = '0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_codes;
		t_bus;
		t_timer;
		end_sim;
	end
	initial begin
		#720000;
		fails++;
		end_sim;
	end
endmodule
bind cwd_top cwd_top_props cwd_top_props_i (.clk_sys_in, .resetn_in,
	.pwrite_in, .paddr_in, .pready_out, .pslverr_out, .prdata_out, .cfg_out,
	.wdog_reset_out, .tmr_ovf_out);
`default_nettype wire
